/* rtl/shu_top.sv */
`timescale 1ns/1ns
`default_nettype none
`include "shu_defs.svh"

// Behaviour
// - immediate count is bit 8 and 3..0
// - register count uses only bits 4..0
// - four-bit codes select local registers
// - destination-set bit picks global or local
// - decode eight-bit register-count shift opcodes
// - decode seven- and six-bit immediate opcodes
// - arithmetic right fills with sign bits
// - logical right fills with zeros
// - left shifts fill low bits with zeros
// - double right uses register pair, high first
// - double left uses same register pair
// - double shift takes two cycles, high first
// - zero on whole result, negative bit 31
// - right shift carry is last bit out
// - immediate arithmetic right treats operand signed
// - logical right treats operand unsigned
// - register arithmetic right fills sign, sets carry
module shu_top #(
   parameter logic [6:0] LEFT_DBL_IMM_OP = `SHU_OP7_LEFT_DBL_IMM
) (
   // clock, reset, enable
   input  wire logic              clk,
   input  wire logic              rst,
   input  wire logic              ce,
   // instruction issue
   input  wire logic              issue_valid,
   input  wire logic [15:0]       instr,
   output logic                   issue_ready,
   // operand values read by the register file
   input  wire logic [31:0]       dst_word,
   input  wire logic [31:0]       pair_word,
   input  wire logic [31:0]       count_word,
   // result write port
   output shu_pkg::shu_wr_s       wr,
   // condition flags
   output shu_pkg::shu_flags_s    flags,
   output logic                   flag_zn_we,
   output logic                   flag_c_we,
   output logic                   flag_v_we,
   // unrecognised opcode
   output logic                   illegal
);

   // operations still in flight
   typedef enum logic {
      st_idle,
      st_low_word
   } shu_state_e;

   // seven-bit view of an eight-bit opcode
   function automatic logic [6:0] op7_of(input logic [7:0] op8);
      op7_of = op8[7:1];
   endfunction : op7_of

   // six-bit view of a seven-bit opcode
   function automatic logic [5:0] op6_of(input logic [6:0] op7);
      op6_of = op7[6:1];
   endfunction : op6_of

   // opcode must not collide with fixed ones
   // refused while elaborating: it would shadow or be shadowed by a fixed decode
   if (LEFT_DBL_IMM_OP == `SHU_OP7_ARIGHT_DBL_IMM ||
       LEFT_DBL_IMM_OP == op7_of(`SHU_OP8_LEFT_SGL_REG) ||
       LEFT_DBL_IMM_OP == op7_of(`SHU_OP8_LEFT_DBL_REG) ||
       LEFT_DBL_IMM_OP == op7_of(`SHU_OP8_LRIGHT_SGL_REG) ||
       LEFT_DBL_IMM_OP == op7_of(`SHU_OP8_ARIGHT_SGL_REG) ||
       op6_of(LEFT_DBL_IMM_OP) == `SHU_OP6_ARIGHT_SGL_IMM ||
       op6_of(LEFT_DBL_IMM_OP) == `SHU_OP6_LEFT_SGL_IMM) begin : g_op_clash
      $error("shu_top: LEFT_DBL_IMM_OP collides");
   end

   shu_pkg::shu_dec_s   dec;          // decoded instruction
   shu_state_e          state_reg;    // sequencer state
   shu_state_e          state_next;   // sequencer next state
   logic [31:0]         low_reg;      // low word parked for cycle two
   logic [3:0]          pair_idx_reg; // partner register index
   logic                zero_reg;     // zero flag held for cycle two
   logic                neg_reg;      // negative flag held
   logic                carry_reg;    // carry held for cycle two
   logic                right_reg;    // right shift in flight
   logic                accept;       // instruction taken this cycle
   logic                known;        // opcode recognised
   logic [4:0]          count;        // effective shift count
   logic [63:0]         src64;        // operand, high word on top
   logic                fill;         // bit entering from the left
   logic [64:0]         rin;          // operand with guard bit
   logic [64:0]         rout;         // right shifted with guard
   logic [63:0]         lout;         // left shifted
   logic [63:0]         res64;        // shifted result
   logic                res_carry;    // last bit shifted out
   logic                res_zero;     // whole result is zero
   logic                take_known;   // recognised shift taken
   logic [1:0]          word_zero;    // zero of each result word

   // field decoder, shared attribute table
   shu_decode #(
      .LEFT_DBL_IMM_OP (LEFT_DBL_IMM_OP)
   ) u_decode (
      .instr (instr),
      .dec   (dec)
   );

   assign known  = (dec.op != shu_pkg::op_none);
   // ready is a flop, so taking depends only on it, ce and issue_valid
   assign accept = ce & issue_valid & issue_ready;
   // only recognised shifts start the datapath sequence
   assign take_known = accept & known;

   // mask of sign copies for a right shift by n
   function automatic logic [64:0] sign_mask(input logic [4:0] n);
      logic [64:0] ones;
      ones = {65{1'b1}};
      sign_mask = ~(ones >> n);
   endfunction : sign_mask

   // shift datapath
   // one right and one left shifter serve every form; a single word
   // rides in the high half so both widths share the same logic
   always_comb begin
      if (dec.use_reg_count) begin
         count = count_word[`SHU_CNT_MSB:0];
      end else begin
         count = dec.count_imm;
      end
      if (dec.is_double) begin
         src64 = {dst_word, pair_word};
      end else begin
         // single word rides in the high half
         src64 = {dst_word, `SHU_RST_WORD};
      end
      // arithmetic fill is the sign bit
      fill = dec.is_arith & dst_word[31];
      // guard bit below catches the last bit out
      rin  = {src64, 1'b0};
      if (fill) begin
         rout = (rin >> count) | sign_mask(count);
      end else begin
         rout = rin >> count;
      end
      // zeros shifted in from the right
      lout = src64 << count;
      if (dec.is_right) begin
         res64 = rout[64:1];
      end else begin
         res64 = lout;
      end
      // last bit out sits just below result
      // zero count gives no bit out, carry clear
      if (dec.is_double) begin
         res_carry = rout[0];
      end else begin
         res_carry = rout[32];
      end
   end

   // zero detect, one slice per word of the result
   for (genvar w = 0; w < 2; w++) begin : g_word_zero
      // each word is tested on its own, then combined
      assign word_zero[w] = (res64[32*w +: 32] == `SHU_RST_WORD);
   end

   // zero over the whole result
   // a single word lives in the high half, so only that word counts
   assign res_zero = dec.is_double ? (&word_zero) : word_zero[1];

   // next state
   always_comb begin
      state_next = state_reg;
      case (state_reg)
         st_idle: begin
            // double shifts need a second cycle
            if (take_known && dec.is_double) begin
               state_next = st_low_word;
            end
         end
         st_low_word: begin
            if (ce) begin
               state_next = st_idle;
            end
         end
         default: begin
            state_next = st_idle;
         end
      endcase
   end

   // sequencer state
   // frozen with ce, so a stalled pair keeps its place
   always_ff @(posedge clk or posedge rst) begin
      if (rst) begin
         state_reg <= st_idle;
      end else if (ce) begin
         state_reg <= state_next;
      end
   end

   // issue ready, low during the second cycle of a pair
   // registered, so the issuer never sees a combinational path
   always_ff @(posedge clk or posedge rst) begin
      if (rst) begin
         issue_ready <= 1'b0;
      end else if (ce) begin
         issue_ready <= (state_next == st_idle);
      end
   end

   // low result word, partner index and flags parked for the low-word cycle
   always_ff @(posedge clk or posedge rst) begin
      if (rst) begin
         low_reg      <= `SHU_RST_WORD;
         pair_idx_reg <= `SHU_RST_IDX;
         zero_reg     <= 1'b0;
         neg_reg      <= 1'b0;
         carry_reg    <= 1'b0;
         right_reg    <= 1'b0;
      end else if (take_known) begin
         // parked for singles too; only the second cycle reads it
         low_reg      <= res64[31:0];
         // partner register follows, wrapping at L15
         pair_idx_reg <= dec.dst_idx + 4'h1;
         zero_reg     <= res_zero;
         neg_reg      <= res64[63];
         carry_reg    <= res_carry;
         right_reg    <= dec.is_right;
      end
   end

   // result write port
   always_ff @(posedge clk or posedge rst) begin
      if (rst) begin
         wr <= '0;
      end else if (ce) begin
         if (state_reg == st_low_word) begin
            // low word in the second cycle
            wr.en        <= 1'b1;
            // partner register is always a local one
            wr.is_global <= 1'b0;
            wr.idx       <= pair_idx_reg;
            wr.data      <= low_reg;
         end else if (take_known) begin
            wr.en        <= 1'b1;
            wr.is_global <= dec.dst_global;
            wr.idx       <= dec.dst_idx;
            wr.data      <= res64[63:32];
         end else begin
            // idle cycle, fields hold their last value
            wr.en <= 1'b0;
         end
      end
   end

   // flags and their write enables
   always_ff @(posedge clk or posedge rst) begin
      if (rst) begin
         flags      <= '0;
         flag_zn_we <= 1'b0;
         flag_c_we  <= 1'b0;
         flag_v_we  <= 1'b0;
      end else if (ce) begin
         // overflow is never defined here, so never written
         flag_v_we <= 1'b0;
         if (state_reg == st_low_word) begin
            // pair flags land with the final write
            // zero and negative from whole pair
            flags.z    <= zero_reg;
            flags.n    <= neg_reg;
            flags.c    <= carry_reg;
            flag_zn_we <= 1'b1;
            flag_c_we  <= right_reg;
         end else if (take_known && !dec.is_double) begin
            // a pair holds its flags back until the low word
            // single word flags at once
            flags.z    <= res_zero;
            flags.n    <= res64[63];
            flags.c    <= res_carry;
            flag_zn_we <= 1'b1;
            flag_c_we  <= dec.is_right;
         end else begin
            flag_zn_we <= 1'b0;
            flag_c_we  <= 1'b0;
         end
      end
   end

   // unknown opcode is dropped with a one-cycle pulse
   // the issuer may trap on it; no register or flag changes
   always_ff @(posedge clk or posedge rst) begin
      if (rst) begin
         illegal <= 1'b0;
      end else if (ce) begin
         illegal <= accept & ~known;
      end
   end

endmodule : shu_top
`default_nettype wire

/* rtl/shu_defs.svh */
`ifndef SHU_DEFS_SVH
`define SHU_DEFS_SVH

// opcode field slices of the 16-bit instruction word
`define SHU_OP_MSB      15
`define SHU_OP8_LSB     8
`define SHU_OP7_LSB     9
`define SHU_OP6_LSB     10

// eight-bit opcodes, register count forms
`define SHU_OP8_LEFT_SGL_REG   8'h8B
`define SHU_OP8_LEFT_DBL_REG   8'h8A
`define SHU_OP8_LRIGHT_SGL_REG 8'h83
`define SHU_OP8_ARIGHT_SGL_REG 8'h87

// seven- and six-bit opcodes, immediate forms
`define SHU_OP7_ARIGHT_DBL_IMM 7'h42
`define SHU_OP6_ARIGHT_SGL_IMM 6'h29
`define SHU_OP6_LEFT_SGL_IMM   6'h2A
`define SHU_OP7_LEFT_DBL_IMM   7'h44

// operand fields
`define SHU_NHI_BIT     8
`define SHU_DSET_BIT    9
`define SHU_DST_MSB     7
`define SHU_DST_LSB     4
`define SHU_SRC_MSB     3
`define SHU_SRC_LSB     0
`define SHU_CNT_MSB     4

// reset values
`define SHU_RST_WORD    32'h0000_0000
`define SHU_RST_IDX     4'h0

`endif

/* rtl/shu_pkg.sv */
`default_nettype none
package shu_pkg;

   // recognised shift operations
   typedef enum logic [3:0] {
      op_none,
      op_arith_right_single_reg,
      op_logic_right_single_reg,
      op_left_single_reg,
      op_left_double_reg,
      op_arith_right_double_imm,
      op_arith_right_single_imm,
      op_left_single_imm,
      op_left_double_imm
   } shu_op_e;

   // decoded instruction
   typedef struct packed {
      shu_op_e    op;
      logic       is_double;
      logic       is_right;
      logic       is_arith;
      logic       use_reg_count;
      logic [4:0] count_imm;
      logic       dst_global;
      logic [3:0] dst_idx;
   } shu_dec_s;

   // condition flags
   typedef struct packed {
      logic z;
      logic n;
      logic c;
      logic v;
   } shu_flags_s;

   // register file write port
   typedef struct packed {
      logic        en;
      logic        is_global;  // destination is a global register
      logic [3:0]  idx;
      logic [31:0] data;
   } shu_wr_s;

endpackage : shu_pkg
`default_nettype wire

/* rtl/shu_decode.sv */
`timescale 1ns/1ns
`default_nettype none
`include "shu_defs.svh"

module shu_decode #(
   parameter logic [6:0] LEFT_DBL_IMM_OP = `SHU_OP7_LEFT_DBL_IMM
) (
   // instruction in
   input  wire logic [15:0]      instr,
   // decoded fields out
   output shu_pkg::shu_dec_s     dec
);

   logic [7:0] op8;   // full eight-bit opcode
   logic [6:0] op7;   // seven-bit opcode
   logic [5:0] op6;   // six-bit opcode

   assign op8 = instr[`SHU_OP_MSB:`SHU_OP8_LSB];
   assign op7 = instr[`SHU_OP_MSB:`SHU_OP7_LSB];
   assign op6 = instr[`SHU_OP_MSB:`SHU_OP6_LSB];

   // opcode match, longest opcodes first
   always_comb begin
      dec = '0;
      dec.op = shu_pkg::op_none;
      dec.count_imm = {instr[`SHU_NHI_BIT],
                       instr[`SHU_SRC_MSB:`SHU_SRC_LSB]};
      dec.dst_idx = instr[`SHU_DST_MSB:`SHU_DST_LSB];
      if (op8 == `SHU_OP8_LEFT_SGL_REG) begin
         dec.op = shu_pkg::op_left_single_reg;
      end else if (op8 == `SHU_OP8_LEFT_DBL_REG) begin
         dec.op = shu_pkg::op_left_double_reg;
      end else if (op8 == `SHU_OP8_LRIGHT_SGL_REG) begin
         dec.op = shu_pkg::op_logic_right_single_reg;
      end else if (op8 == `SHU_OP8_ARIGHT_SGL_REG) begin
         dec.op = shu_pkg::op_arith_right_single_reg;
      end else if (op7 == `SHU_OP7_ARIGHT_DBL_IMM) begin
         dec.op = shu_pkg::op_arith_right_double_imm;
      end else if (op7 == LEFT_DBL_IMM_OP) begin
         dec.op = shu_pkg::op_left_double_imm;
      end else if (op6 == `SHU_OP6_ARIGHT_SGL_IMM) begin
         dec.op = shu_pkg::op_arith_right_single_imm;
      end else if (op6 == `SHU_OP6_LEFT_SGL_IMM) begin
         dec.op = shu_pkg::op_left_single_imm;
      end
      // operation attributes
      case (dec.op)
         shu_pkg::op_arith_right_single_reg,
         shu_pkg::op_logic_right_single_reg,
         shu_pkg::op_left_single_reg: begin
            dec.use_reg_count = 1'b1;
         end
         shu_pkg::op_left_double_reg: begin
            dec.use_reg_count = 1'b1;
            dec.is_double     = 1'b1;
         end
         shu_pkg::op_arith_right_double_imm,
         shu_pkg::op_left_double_imm: begin
            dec.is_double = 1'b1;
         end
         shu_pkg::op_arith_right_single_imm,
         shu_pkg::op_left_single_imm: begin
            dec.dst_global = ~instr[`SHU_DSET_BIT];
         end
         default: begin
            dec.use_reg_count = 1'b0;
         end
      endcase
      dec.is_right = (dec.op == shu_pkg::op_arith_right_single_reg)
                   | (dec.op == shu_pkg::op_logic_right_single_reg)
                   | (dec.op == shu_pkg::op_arith_right_double_imm)
                   | (dec.op == shu_pkg::op_arith_right_single_imm);
      dec.is_arith = dec.is_right
                   & (dec.op != shu_pkg::op_logic_right_single_reg);
   end

endmodule : shu_decode
`default_nettype wire

/* test/shu_top_chk.sv */
`timescale 1ns/1ns
`default_nettype none
`include "shu_defs.svh"
// protocol watcher on the shift unit ports
module shu_top_chk #(
   parameter logic [6:0] LEFT_DBL_IMM_OP = `SHU_OP7_LEFT_DBL_IMM
) (
   // clock, reset, enable
   input wire logic                clk,
   input wire logic                rst,
   input wire logic                ce,
   // issue side
   input wire logic                issue_valid,
   input wire logic [15:0]         instr,
   input wire logic                issue_ready,
   input wire logic [31:0]         dst_word,
   input wire logic [31:0]         pair_word,
   input wire logic [31:0]         count_word,
   // results
   input wire shu_pkg::shu_wr_s    wr,
   input wire shu_pkg::shu_flags_s flags,
   input wire logic                flag_zn_we,
   input wire logic                flag_c_we,
   input wire logic                flag_v_we,
   input wire logic                illegal
);
   logic take;  // instruction accepted this edge
   assign take = issue_valid && issue_ready && ce;
   default clocking @(posedge clk); endclocking
   default disable iff (rst);
   a_illegal_quiet: assert property (
      illegal |-> !wr.en && !flag_zn_we) else $error("illegal wrote");
   a_v_never_set: assert property (
      !flag_v_we) else $error("v written");
   a_shl_no_carry: assert property (
      take && instr[15:8] == 8'h8B |=> wr.en && flag_zn_we && !flag_c_we)
      else $error("left single timing");
   a_shr_carry_we: assert property (
      take && instr[15:8] == 8'h83 |=> wr.en && flag_c_we && !wr.is_global)
      else $error("right single timing");
   a_dbl_two_cycle: assert property (
      take && instr[15:8] == 8'h8A |=> wr.en && !flag_zn_we ##1
      wr.en && flag_zn_we) else $error("double not two words");
   a_dbl_ready_gap: assert property (
      wr.en && !flag_zn_we |-> !issue_ready ##1 issue_ready)
      else $error("ready gap wrong");
   a_dst_local_idx: assert property (
      take && instr[15:8] == 8'h8B |=> wr.idx == $past(instr[7:4])
      && !wr.is_global) else $error("dest index");
   a_zero_count: assert property (
      take && instr[15:8] == 8'h8B && count_word[4:0] == 5'h00
      |=> wr.data == $past(dst_word)) else $error("zero count");
   a_global_pick: assert property (
      take && instr[15:10] inside {6'h29, 6'h2A}
      |=> wr.is_global == !$past(instr[9])) else $error("dest set bit");
   a_sign_fill: assert property (
      take && instr[15:10] == 6'h29 && dst_word[31] |=> wr.data[31])
      else $error("sign fill");
   a_dbl_imm_pair: assert property (
      take && instr[15:9] == LEFT_DBL_IMM_OP |=> ##1
      wr.en && wr.idx == $past(instr[7:4], 2) + 4'h1)
      else $error("pair index");
endmodule : shu_top_chk
bind shu_top shu_top_chk #(.LEFT_DBL_IMM_OP(LEFT_DBL_IMM_OP)) u_chk (
   .clk(clk), .rst(rst), .ce(ce), .issue_valid(issue_valid),
   .instr(instr), .issue_ready(issue_ready), .dst_word(dst_word),
   .pair_word(pair_word), .count_word(count_word), .wr(wr),
   .flags(flags), .flag_zn_we(flag_zn_we), .flag_c_we(flag_c_we),
   .flag_v_we(flag_v_we), .illegal(illegal));
`default_nettype wire

/* test/shu_rf_model.sv */
`timescale 1ns/1ns
`default_nettype none
// register file model: locals 0..15, globals 16..31
module shu_rf_model (
   // clock
   input  wire logic             clk,
   // instruction and write port
   input  wire logic [15:0]      instr,
   input  wire shu_pkg::shu_wr_s wr,
   // operand reads
   output logic [31:0]           dst_word,
   output logic [31:0]           pair_word,
   output logic [31:0]           count_word
);
   logic [31:0] rf [32];  // bench preloads it, so no always_ff
   logic        glob;     // global destination
   assign glob = (instr[15:10] == 6'h29 || instr[15:10] == 6'h2A)
                 && !instr[9];
   assign dst_word   = rf[{glob, instr[7:4]}];
   assign pair_word  = rf[{1'b0, instr[7:4] + 4'h1}];
   assign count_word = rf[{1'b0, instr[3:0]}];
   // write back of results
   always @(posedge clk) begin
      if (wr.en) begin
         rf[{wr.is_global, wr.idx}] <= wr.data;
      end
   end
endmodule : shu_rf_model
`default_nettype wire

/* test/shu_top_test.sv */
`timescale 1ns/1ns
`default_nettype none
module shu_top_test;
   logic               clk = 1'b0;
   logic               rst = 1'b1;
   logic               ce = 1'b1;
   logic               issue_valid = 1'b0;
   logic [15:0]        instr = 16'h0000;
   logic [31:0]        dst_word, pair_word, count_word;
   shu_pkg::shu_wr_s    wr;
   shu_pkg::shu_flags_s flags;
   logic               issue_ready, flag_zn_we, flag_c_we;
   logic               flag_v_we, illegal;
   int                 n_errors = 0;
   int                 samples_checked = 0;
   logic [31:0]        lf = 32'h0000_F01C;  // lfsr state
   always #5 clk = ~clk;
   shu_top u_dut (.clk(clk), .rst(rst), .ce(ce),
      .issue_valid(issue_valid), .instr(instr), .issue_ready(issue_ready),
      .dst_word(dst_word), .pair_word(pair_word), .count_word(count_word),
      .wr(wr), .flags(flags), .flag_zn_we(flag_zn_we),
      .flag_c_we(flag_c_we), .flag_v_we(flag_v_we), .illegal(illegal));
   shu_rf_model u_rf (.clk(clk), .instr(instr), .wr(wr),
      .dst_word(dst_word), .pair_word(pair_word), .count_word(count_word));
   function automatic logic [31:0] step(input logic [31:0] s);
      return {s[30:0], s[31] ^ s[21] ^ s[1] ^ s[0]};
   endfunction : step
   task automatic close_out;
      $display("checked %0d errors %0d", samples_checked, n_errors);
      if (n_errors == 0 && samples_checked > 0) begin
         $display("Testbench passed");
      end else begin
         $display("Testbench failed");
      end
      $finish;
   endtask : close_out
   task automatic chk_bit(input logic g, input logic e, input string m);
      samples_checked++;
      if (g !== e) begin
         $display("[ERR] %0t bit %s", $time, m);
         n_errors++;
      end
   endtask : chk_bit
   task automatic chk_word(input logic [31:0] g, input logic [31:0] e,
                           input string m);
      samples_checked++;
      if (g !== e) begin
         $display("[ERR] %0t %s %h/%h", $time, m, g, e);
         n_errors++;
      end
   endtask : chk_word
   // issue one instruction and check every answer against the model
   // frz holds the enable low over the first offered edge
   task automatic run(input logic [15:0] i, input logic frz);
      logic        dbl, rt, ar, rc, gl, cy, ok;
      logic [4:0]  n;
      logic [31:0] d, p;
      logic [63:0] v, r;
      int          k;
      dbl = i[15:9] inside {7'h42, 7'h44} || i[15:8] == 8'h8A;
      rt = i[15:9] == 7'h42 || i[15:10] == 6'h29 ||
           i[15:8] inside {8'h83, 8'h87};
      ar = rt && i[15:8] != 8'h83;
      rc = i[15:8] inside {8'h83, 8'h87, 8'h8A, 8'h8B};
      ok = rt || dbl || rc || i[15:10] == 6'h2A;
      gl = i[15:10] inside {6'h29, 6'h2A} && !i[9];
      d = u_rf.rf[{gl, i[7:4]}];
      p = u_rf.rf[{1'b0, i[7:4] + 4'h1}];
      n = rc ? u_rf.rf[{1'b0, i[3:0]}][4:0] : {i[8], i[3:0]};
      v = dbl ? {d, p} : {(ar ? {32{d[31]}} : 32'h0000_0000), d};
      r = !rt ? v << n : (ar ? 64'($signed(v) >>> n) : v >> n);
      cy = (n != 5'h00) && v[n - 5'h01];
      k = 0;
      while (issue_ready !== 1'b1 && k < 8) begin
         @(posedge clk);
         #1;
         k++;
      end
      if (issue_ready !== 1'b1) begin
         chk_bit(1'b0, 1'b1, "ready");
         close_out;
      end
      @(posedge clk);
      issue_valid <= 1'b1;
      instr <= i;
      ce <= !frz;
      if (frz) begin
         // frozen edge: the offered shift must not be taken yet
         @(posedge clk);
         ce <= 1'b1;
         #1;
         chk_bit(wr.en | flag_zn_we | illegal, 1'b0, "frozen");
      end
      @(posedge clk);
      issue_valid <= 1'b0;
      #1;
      chk_bit(illegal, !ok, "illegal");
      if (!ok) begin
         chk_bit(wr.en, 1'b0, "en");
         return;
      end
      chk_bit(wr.en, 1'b1, "en");
      chk_bit(wr.is_global, gl, "glob");
      chk_word({28'h0, wr.idx}, {28'h0, i[7:4]}, "idx");
      chk_word(wr.data, dbl ? r[63:32] : r[31:0], "data");
      if (dbl) begin
         chk_bit(issue_ready, 1'b0, "gap");
         @(posedge clk);
         #1;
         chk_word({28'h0, wr.idx}, {28'h0, i[7:4] + 4'h1}, "pidx");
         chk_word(wr.data, r[31:0], "low");
      end
      chk_bit(flag_zn_we, 1'b1, "znwe");
      chk_bit(flags.z, dbl ? r == 0 : r[31:0] == 0, "z");
      chk_bit(flags.n, dbl ? r[63] : r[31], "n");
      chk_bit(flag_c_we, rt, "cwe");
      if (rt) chk_bit(flags.c, cy, "c");
      chk_bit(flag_v_we, 1'b0, "vwe");
   endtask : run
   // op table: four register count forms, then four immediate forms
   initial begin
      logic [15:0] ops [8];
      logic [15:0] i;
      logic [4:0]  n;
      ops = '{16'h8B00, 16'h8A00, 16'h8300, 16'h8700,
              16'h8400, 16'hA400, 16'hA800, 16'h8800};
      repeat (10) @(posedge clk);
      rst <= 1'b0;
      #1;
      for (int k = 0; k < 8; k++) begin
         for (int j = 0; j < 12; j++) begin
            // let the last write-back land before the file is reloaded
            @(posedge clk);
            #1;
            // corners: count 0, count 31, sign operand, zero operand
            for (int m = 0; m < 32; m++) begin
               lf = step(lf);
               u_rf.rf[m] = (j == 3) ? 32'h0 :
                            (j == 2) ? 32'h8000_0001 : lf;
            end
            n = (j == 0) ? 5'd0 : (j == 1) ? 5'd31 : lf[4:0];
            i = ops[k];
            i[7:4] = lf[15:12];
            if (k < 4) begin
               // count source kept off the register pair
               i[3:0] = i[7:4] + 4'h2;
               u_rf.rf[{1'b0, i[3:0]}] = {lf[31:5], n};
            end else begin
               i[8] = n[4];
               i[3:0] = n[3:0];
               if (k == 5 || k == 6) i[9] = lf[9];
            end
            run(i, j == 4);
         end
         $display("op group %0d done", k);
      end
      run(16'h0000, 1'b0);
      $display("unknown opcode done");
      close_out;
   end
endmodule : shu_top_test
`default_nettype wire
